// ### rtl/mmpc_params.svh
`ifndef MMPC_PARAMS_SVH
`define MMPC_PARAMS_SVH
// unit count and sample words
`define MMPC_UNITS        4
`define MMPC_SMP          4
`define MMPC_NTRIG        4
`define MMPC_NDIO         32
// system clock and data clock rates
`define MMPC_CLK_MHZ      125
`define MMPC_CLK_PS       8000
`define MMPC_DATA_MHZ     1800
`define MMPC_TS_BASE      (`MMPC_DATA_MHZ / `MMPC_CLK_MHZ)
`define MMPC_TS_REM       (`MMPC_DATA_MHZ % `MMPC_CLK_MHZ)
// period limits, times as printed, counts derived
`define MMPC_PER_MIN_PS   44400
`define MMPC_PER_MAX_S    19
`define MMPC_PER_MIN_CYC  ((`MMPC_PER_MIN_PS + `MMPC_CLK_PS - 1) / `MMPC_CLK_PS)
`define MMPC_PER_MAX_CYC  ((64'd1000000000000 * `MMPC_PER_MAX_S) / `MMPC_CLK_PS)
`define MMPC_PER_RST      32'h0000007D
// register map, byte offsets inside one unit window
`define MMPC_REG_CFG      5'h00
`define MMPC_REG_PER      5'h04
`define MMPC_REG_VAL      5'h08
`define MMPC_REG_TSLO     5'h0C
`define MMPC_REG_TSHI     5'h10
`define MMPC_REG_STAT     5'h14
`define MMPC_REG_NONE     5'h1F
// input select codes
`define MMPC_SEL_DIO      6'h04
`define MMPC_SEL_END      6'h24
`define MMPC_GSEL_AWG     3'h4
`endif

// ### rtl/mmpc_pkg.sv
`include "mmpc_params.svh"
package mmpc_pkg;
    // counter run modes
    typedef enum logic [1:0] {
        MMPC_FREE  = 2'h0,
        MMPC_GATED = 2'h1,
        MMPC_GFREE = 2'h2,
        MMPC_TAG   = 2'h3
    } mmpc_mode_t;
    // arithmetic with the paired unit
    typedef enum logic [1:0] {
        MMPC_OP_NONE = 2'h0,
        MMPC_OP_ADD  = 2'h1,
        MMPC_OP_SUB  = 2'h2,
        MMPC_OP_RSV  = 2'h3
    } mmpc_op_t;
    // time tagging hold-off state
    typedef enum logic {
        MMPC_TG_IDLE = 1'b0,
        MMPC_TG_HOLD = 1'b1
    } mmpc_tg_t;
    // per-unit configuration word
    typedef struct packed {
        logic [14:0] rsv;
        logic [2:0]  gsel;
        logic [5:0]  insel;
        logic        integ;
        mmpc_op_t    op;
        logic        fall;
        logic        rise;
        mmpc_mode_t  mode;
        logic        en;
    } mmpc_cfg_t;
    // avalon-mm request and response
    typedef struct packed {
        logic [6:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } mmpc_av_req_t;
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } mmpc_av_rsp_t;
    // one counter result
    typedef struct packed {
        logic        valid;
        logic [31:0] value;
        logic [63:0] ts;
    } mmpc_res_t;
    // whole state of the block
    typedef struct packed {
        mmpc_cfg_t    [`MMPC_UNITS-1:0]       cfg;
        logic         [`MMPC_UNITS-1:0][31:0] per;
        logic         [`MMPC_UNITS-1:0][31:0] cnt;
        logic         [`MMPC_UNITS-1:0][31:0] tmr;
        logic         [`MMPC_UNITS-1:0][31:0] last;
        logic         [`MMPC_UNITS-1:0][31:0] acc;
        logic         [`MMPC_UNITS-1:0]       sprev;
        logic         [`MMPC_UNITS-1:0]       gprev;
        logic         [`MMPC_UNITS-1:0]       newf;
        mmpc_tg_t     [`MMPC_UNITS-1:0]       tg;
        logic         [`MMPC_UNITS-1:0][63:0] tag_ts;
        mmpc_res_t    [`MMPC_UNITS-1:0]       res;
        logic         [63:0]                  ts;
        logic         [6:0]                   frac;
        mmpc_av_rsp_t                         av;
    } mmpc_st_t;
endpackage

// ### rtl/mmpc_top.sv
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "mmpc_params.svh"
// Operation
// - four independent units, own configuration each
// - counts up to 225 MHz without loss
// - no results while unit disabled
// - free running: clear, count, report per period
// - gated: count between gate rise and fall
// - gated: report total at gate fall
// - gated free running: cleared while gate low
// - gated free running: report after full period
// - tagging: report pulse with its timestamp
// - tagging: period is minimum hold-off
// - tagging: pulses in window summed, reported
// - period programmable 44.4 ns to 19 s
// - count input: four triggers or 32 bits
// - rising edge option counts low-to-high
// - falling edge option, both edges together
// - gate: four triggers or four generator lines
// - add or subtract paired unit output
// - optional integration into running total
// - timestamps in 1.8 GHz clock cycles
module mmpc_top #(
    parameter logic [31:0] PER_MAX_CYC = 32'(`MMPC_PER_MAX_CYC)
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire mmpc_pkg::mmpc_av_req_t  av_req,
    output      mmpc_pkg::mmpc_av_rsp_t  av_rsp,
    input  wire logic [3:0][3:0]         trig_smp,
    input  wire logic [31:0][3:0]        digital_io_bit,
    input  wire logic [3:0]              awg_trig,
    output      mmpc_pkg::mmpc_res_t [3:0] res
);
    import mmpc_pkg::*;

    mmpc_st_t    s;          // registered state
    mmpc_st_t    next_s;     // next state
    logic [3:0]  gate_w;     // selected gate level per unit
    logic [3:0][2:0] ev_w;   // count events this cycle per unit
    logic [3:0]  rv_w;       // raw result strobe per unit
    logic [3:0][31:0] rval_w; // raw result value per unit
    logic [3:0][63:0] rts_w;  // raw result timestamp per unit

    // four samples per clock give 500 MS/s, enough for 225 MHz pulses
    function automatic logic [2:0] mmpc_edges(
        input logic [3:0] smp,
        input logic       prv,
        input logic       rise,
        input logic       fall
    );
        logic [2:0] n;
        logic       q;
        n = 3'h0;
        q = prv;
        for (int k = 0; k < `MMPC_SMP; k++) begin
            if (rise && !q && smp[k]) begin
                n = n + 3'h1;
            end
            if (fall && q && !smp[k]) begin
                n = n + 3'h1;
            end
            q = smp[k];
        end
        return n;
    endfunction

    // count source: trigger inputs first, then the digital bits
    function automatic logic [3:0] mmpc_src(input logic [5:0] sel);
        if (sel < `MMPC_SEL_DIO) begin
            return trig_smp[sel[1:0]];
        end else if (sel < `MMPC_SEL_END) begin
            return digital_io_bit[5'(sel - `MMPC_SEL_DIO)];
        end
        return 4'h0;
    endfunction

    // gate source: last trigger sample or generator line
    function automatic logic mmpc_gate(input logic [2:0] sel);
        if (sel < `MMPC_GSEL_AWG) begin
            return trig_smp[sel[1:0]][`MMPC_SMP-1];
        end
        return awg_trig[sel[1:0]];
    endfunction

    // register decode, shared by read and write paths
    function automatic logic [4:0] mmpc_dec(input logic [6:0] a);
        case (a[4:0])
            `MMPC_REG_CFG, `MMPC_REG_PER, `MMPC_REG_VAL,
            `MMPC_REG_TSLO, `MMPC_REG_TSHI, `MMPC_REG_STAT: begin
                return a[4:0];
            end
            default: begin
                return `MMPC_REG_NONE;
            end
        endcase
    endfunction

    // byte-enable merge of a write into the old word
    function automatic logic [31:0] mmpc_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [31:0] v;
        v = old;
        for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
                v[k*8 +: 8] = wd[k*8 +: 8];
            end
        end
        return v;
    endfunction

    // out-of-range periods are pulled to the nearest limit
    function automatic logic [31:0] mmpc_clamp(input logic [31:0] v);
        if (v < 32'(`MMPC_PER_MIN_CYC)) begin
            return 32'(`MMPC_PER_MIN_CYC);
        end else if (v > PER_MAX_CYC) begin
            return PER_MAX_CYC;
        end
        return v;
    endfunction

    // next-state logic: bus slave, time base, units, arithmetic
    always_comb begin
        logic [1:0]  u;
        logic [4:0]  rg;
        logic [31:0] wv;
        logic [7:0]  fs;
        logic        cy;
        logic [31:0] sum;
        logic        endp;
        logic [31:0] pv;
        logic [31:0] cv;
        logic [3:0]  sv;
        mmpc_cfg_t   c;
        u = av_req.address[6:5];
        rg = mmpc_dec(av_req.address);
        wv = 32'h0;
        fs = 8'h0;
        cy = 1'b0;
        sum = 32'h0;
        endp = 1'b0;
        pv = 32'h0;
        cv = 32'h0;
        sv = 4'h0;
        c = '0;
        next_s = s;
        gate_w = '0;
        ev_w = '0;
        rv_w = '0;
        rval_w = '0;
        rts_w = '0;

        // bus: one wait cycle, then a one-cycle answer
        next_s.av.waitrequest = 1'b1;
        if ((av_req.read || av_req.write) && s.av.waitrequest) begin
            next_s.av.waitrequest = 1'b0;
            case (rg)
                `MMPC_REG_CFG:  next_s.av.readdata = s.cfg[u];
                `MMPC_REG_PER:  next_s.av.readdata = s.per[u];
                `MMPC_REG_VAL:  next_s.av.readdata = s.res[u].value;
                `MMPC_REG_TSLO: next_s.av.readdata = s.res[u].ts[31:0];
                `MMPC_REG_TSHI: next_s.av.readdata = s.res[u].ts[63:32];
                `MMPC_REG_STAT: next_s.av.readdata =
                    {29'h0, s.tg[u], s.gprev[u], s.newf[u]};
                default:        next_s.av.readdata = 32'h0;
            endcase
        end
        if (av_req.write && !s.av.waitrequest) begin
            case (rg)
                `MMPC_REG_CFG: begin
                    wv = mmpc_merge(s.cfg[u], av_req.writedata,
                                    av_req.byteenable);
                    next_s.cfg[u] = wv;
                    next_s.cfg[u].rsv = '0;
                end
                `MMPC_REG_PER: begin
                    wv = mmpc_merge(s.per[u], av_req.writedata,
                                    av_req.byteenable);
                    next_s.per[u] = mmpc_clamp(wv);
                end
                default: begin
                    // read-only or unmapped: write ignored
                end
            endcase
        end
        // reading the value clears its new flag; a new result wins below
        if (av_req.read && !s.av.waitrequest && rg == `MMPC_REG_VAL) begin
            next_s.newf[u] = 1'b0;
        end

        // time base: 14.4 data-clock ticks per system clock
        fs = {1'b0, s.frac} + 8'(`MMPC_TS_REM);
        cy = fs >= 8'(`MMPC_CLK_MHZ);
        next_s.frac = cy ? 7'(fs - 8'(`MMPC_CLK_MHZ)) : fs[6:0];
        next_s.ts = s.ts + 64'(`MMPC_TS_BASE) + {63'h0, cy};

        // per-unit counting, all four alike
        for (int i = 0; i < `MMPC_UNITS; i++) begin
            c = s.cfg[i];
            sv = mmpc_src(c.insel);
            ev_w[i] = mmpc_edges(sv, s.sprev[i], c.rise, c.fall);
            gate_w[i] = mmpc_gate(c.gsel);
            next_s.sprev[i] = sv[`MMPC_SMP-1];
            next_s.gprev[i] = gate_w[i];
            sum = s.cnt[i] + {29'h0, ev_w[i]};
            endp = s.tmr[i] >= s.per[i] - 32'h1;
            rts_w[i] = s.ts;
            if (!c.en) begin
                next_s.cnt[i] = 32'h0;
                next_s.tmr[i] = 32'h0;
                next_s.tg[i] = MMPC_TG_IDLE;
                next_s.acc[i] = 32'h0;
            end else begin
                case (c.mode)
                    MMPC_FREE, MMPC_GFREE: begin
                        if (c.mode == MMPC_GFREE && !gate_w[i]) begin
                            next_s.cnt[i] = 32'h0;
                            next_s.tmr[i] = 32'h0;
                        end else if (endp) begin
                            rv_w[i] = 1'b1;
                            rval_w[i] = sum;
                            next_s.cnt[i] = 32'h0;
                            next_s.tmr[i] = 32'h0;
                        end else begin
                            next_s.cnt[i] = sum;
                            next_s.tmr[i] = s.tmr[i] + 32'h1;
                        end
                    end
                    MMPC_GATED: begin
                        if (gate_w[i]) begin
                            next_s.cnt[i] = s.gprev[i] ?
                                sum : {29'h0, ev_w[i]};
                        end else if (s.gprev[i]) begin
                            rv_w[i] = 1'b1;
                            rval_w[i] = s.cnt[i];
                            next_s.cnt[i] = 32'h0;
                        end else begin
                            next_s.cnt[i] = 32'h0;
                        end
                    end
                    MMPC_TAG: begin
                        case (s.tg[i])
                            MMPC_TG_IDLE: begin
                                if (ev_w[i] != 3'h0) begin
                                    rv_w[i] = 1'b1;
                                    rval_w[i] = {29'h0, ev_w[i]};
                                    next_s.tg[i] = MMPC_TG_HOLD;
                                    next_s.tmr[i] = 32'h0;
                                    next_s.cnt[i] = 32'h0;
                                end
                            end
                            MMPC_TG_HOLD: begin
                                if (s.cnt[i] == 32'h0 && ev_w[i] != 3'h0) begin
                                    next_s.tag_ts[i] = s.ts;
                                end
                                if (!endp) begin
                                    next_s.cnt[i] = sum;
                                    next_s.tmr[i] = s.tmr[i] + 32'h1;
                                end else if (sum != 32'h0) begin
                                    rv_w[i] = 1'b1;
                                    rval_w[i] = sum;
                                    rts_w[i] = (s.cnt[i] == 32'h0) ?
                                        s.ts : s.tag_ts[i];
                                    next_s.cnt[i] = 32'h0;
                                    next_s.tmr[i] = 32'h0;
                                end else begin
                                    next_s.tg[i] = MMPC_TG_IDLE;
                                end
                            end
                            default: begin
                                next_s.tg[i] = MMPC_TG_IDLE;
                            end
                        endcase
                    end
                    default: begin
                        next_s.cnt[i] = 32'h0;
                    end
                endcase
            end
        end

        // pairing arithmetic and integration; partner is index xor 1
        for (int i = 0; i < `MMPC_UNITS; i++) begin
            c = s.cfg[i];
            pv = rv_w[i ^ 1] ? rval_w[i ^ 1] : s.last[i ^ 1];
            case (c.op)
                MMPC_OP_ADD: cv = rval_w[i] + pv;
                MMPC_OP_SUB: cv = rval_w[i] - pv;
                default:     cv = rval_w[i];
            endcase
            next_s.res[i].valid = rv_w[i];
            if (rv_w[i]) begin
                next_s.last[i] = rval_w[i];
                next_s.newf[i] = 1'b1;
                next_s.res[i].ts = rts_w[i];
                if (c.integ) begin
                    next_s.acc[i] = s.acc[i] + cv;
                    next_s.res[i].value = s.acc[i] + cv;
                end else begin
                    next_s.res[i].value = cv;
                end
            end
        end

        // synchronous reset overrides everything
        if (rst) begin
            next_s = '0;
            next_s.av.waitrequest = 1'b1;
            for (int i = 0; i < `MMPC_UNITS; i++) begin
                next_s.per[i] = `MMPC_PER_RST;
            end
        end
    end

    // single state register
    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // outputs straight from state flops
    assign av_rsp = s.av;
    assign res = s.res;

    default clocking mmpc_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // first tagged pulse: report and enter hold-off
    sequence tag_idle_hit;
        s.cfg[0].en && s.cfg[0].mode == MMPC_TAG &&
        s.tg[0] == MMPC_TG_IDLE && ev_w[0] != 3'h0;
    endsequence
    sequence tag_reported;
        s.res[0].valid && s.tg[0] == MMPC_TG_HOLD;
    endsequence
    // bus request and its answer
    sequence bus_req;
        (av_req.read || av_req.write) && s.av.waitrequest;
    endsequence
    sequence bus_done;
        !s.av.waitrequest ##1 s.av.waitrequest;
    endsequence

    off_silent_a: assert property (
        !s.cfg[0].en |=> !s.res[0].valid)
        else $error("disabled unit produced a result");
    free_period_a: assert property (
        s.cfg[0].en && s.cfg[0].mode == MMPC_FREE &&
        s.tmr[0] >= s.per[0] - 32'h1
        |=> s.res[0].valid && s.cnt[0] == 32'h0 && s.tmr[0] == 32'h0)
        else $error("free running period end not reported");
    gate_count_a: assert property (
        s.cfg[0].en && s.cfg[0].mode == MMPC_GATED &&
        gate_w[0] && s.gprev[0]
        |=> !s.res[0].valid &&
            s.cnt[0] == $past(s.cnt[0]) + 32'($past(ev_w[0])))
        else $error("gated count wrong while gate high");
    gate_fall_a: assert property (
        s.cfg[0].en && s.cfg[0].mode == MMPC_GATED &&
        s.gprev[0] && !gate_w[0]
        |=> s.res[0].valid && s.cnt[0] == 32'h0)
        else $error("gate fall did not report");
    gfree_clear_a: assert property (
        s.cfg[0].en && s.cfg[0].mode == MMPC_GFREE && !gate_w[0]
        |=> s.cnt[0] == 32'h0 && s.tmr[0] == 32'h0 && !s.res[0].valid)
        else $error("gated free running not held while gate low");
    tag_first_a: assert property (
        tag_idle_hit |=> tag_reported)
        else $error("tagged pulse not reported");
    tag_holdoff_a: assert property (
        s.cfg[0].en && s.cfg[0].mode == MMPC_TAG &&
        s.tg[0] == MMPC_TG_HOLD && s.tmr[0] < s.per[0] - 32'h1
        |=> !s.res[0].valid)
        else $error("report inside hold-off window");
    tag_sum_a: assert property (
        s.cfg[0].en && s.cfg[0].mode == MMPC_TAG &&
        s.tg[0] == MMPC_TG_HOLD && s.tmr[0] >= s.per[0] - 32'h1 &&
        s.cnt[0] != 32'h0
        |=> s.res[0].valid && s.res[0].ts == $past(s.tag_ts[0]))
        else $error("window sum not reported with its tag");
    period_range_a: assert property (
        s.per[0] >= 32'(`MMPC_PER_MIN_CYC) && s.per[0] <= PER_MAX_CYC)
        else $error("period outside limits");
    ts_step_a: assert property (
        !$past(rst) |-> (s.ts - $past(s.ts)) inside
            {64'(`MMPC_TS_BASE), 64'(`MMPC_TS_BASE) + 64'h1})
        else $error("timestamp step wrong");
    arith_none_a: assert property (
        rv_w[0] && s.cfg[0].op == MMPC_OP_NONE && !s.cfg[0].integ
        |=> s.res[0].valid && s.res[0].value == $past(rval_w[0]))
        else $error("arithmetic none altered the count");
    bus_ack_a: assert property (
        bus_req |=> bus_done)
        else $error("bus answer not one cycle");
endmodule

// ### bench/mmpc_src.sv
`timescale 1ns/1ns
// far side: pulse sources and gate lines, plain levels
module mmpc_src (
    input  wire logic             clk,
    input  wire logic             run,
    input  wire logic             fast,
    input  wire logic             gate,
    input  wire logic [5:0]       src,
    input  wire logic [2:0]       gsrc,
    output      logic [3:0][3:0]  trig_smp = '0,
    output      logic [31:0][3:0] digital_io_bit = '0,
    output      logic [3:0]       awg_trig = '0
);
    logic [3:0] pat;  // one clock of samples, bit0 earliest
    // fast gives two pulses per clock, above the top count rate
    assign pat = fast ? 4'h5 : 4'h3;
    // quiet lines sit low; only the chosen source and gate move
    always_ff @(posedge clk) begin
        trig_smp <= '0;
        digital_io_bit <= '0;
        awg_trig <= '0;
        if (run && src < 6'h04) trig_smp[src[1:0]] <= pat;
        if (run && src >= 6'h04) digital_io_bit[5'(src - 6'h04)] <= pat;
        if (gate && !gsrc[2]) trig_smp[gsrc[1:0]] <= 4'hF;
        if (gate && gsrc[2]) awg_trig[gsrc[1:0]] <= 1'b1;
    end
endmodule

// ### bench/mmpc_top_test.sv
`timescale 1ns/1ns
`include "mmpc_params.svh"
module mmpc_top_test;
    import mmpc_pkg::*;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    mmpc_av_req_t     av_req = '0;
    mmpc_av_rsp_t     av_rsp;
    logic [3:0][3:0]  trig_smp;
    logic [31:0][3:0] digital_io_bit;
    logic [3:0]       awg_trig;
    mmpc_res_t [3:0]  res;
    logic             run = 1'b0;   // pulse train on
    logic             fast = 1'b0;  // double pulse rate
    logic             gate = 1'b0;  // gate level
    logic [5:0]       src = 6'h04;  // line carrying pulses
    logic [2:0]       gsrc = 3'h0;  // line carrying the gate
    int               n_mismatch = 0;
    int               cmp_count = 0;
    int               cyc = 0;      // cycle stamp for spacing checks

    // short period ceiling keeps the clamp visible in sim
    mmpc_top #(.PER_MAX_CYC(32'h000003E8)) mmpc_top_i (
        .clk(clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp),
        .trig_smp(trig_smp), .digital_io_bit(digital_io_bit),
        .awg_trig(awg_trig), .res(res));
    mmpc_src mmpc_src_i (
        .clk(clk), .run(run), .fast(fast), .gate(gate), .src(src),
        .gsrc(gsrc), .trig_smp(trig_smp),
        .digital_io_bit(digital_io_bit), .awg_trig(awg_trig));

    initial forever #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input int u, input logic [4:0] off,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        av_req <= '{{2'(u), off}, !wr, wr, 4'hF, d};
        do begin
            @(posedge clk);
            n++;
        end while (av_rsp.waitrequest !== 1'b0 && n < 50);
        chk("bus answer", 1, n < 50);
        q = av_rsp.readdata;
        av_req <= '0;
    endtask
    task automatic wr(input int u, input logic [4:0] off,
                      input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, u, off, d, q);
    endtask
    function automatic logic [31:0] cf(mmpc_mode_t m, logic [1:0] ef,
        mmpc_op_t op, int ig, int s, int g);
        return {15'h0000, 3'(g), 6'(s), 1'(ig), op, ef, m, 1'b1};
    endfunction
    // waits a bounded time for one result of unit u
    task automatic getres(input int u, input int lim, output logic f,
        output logic [31:0] v, output logic [63:0] t, output int at);
        f = 1'b0;
        for (int n = 0; n < lim && !f; n++) begin
            @(posedge clk);
            f = (res[u].valid === 1'b1);
            v = res[u].value;
            t = res[u].ts;
            at = cyc;
        end
    endtask
    task automatic nxt(input int u, output logic [31:0] v,
                       output logic [63:0] t, output int at);
        logic f;
        getres(u, 300, f, v, t, at);
        chk("result seen", 1, f);
    endtask
    // first result after a change may straddle it, so judge the second
    task automatic run_free(input int u, input logic [31:0] c,
                            input logic [31:0] exp);
        logic [31:0] v;
        logic [63:0] t;
        int a;
        wr(u, `MMPC_REG_CFG, c);
        repeat (2) nxt(u, v, t, a);
        chk("free count", exp, v);
    endtask
    task automatic pulse;
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
    endtask

    task automatic t_regs;
        logic [31:0] q;
        bus(1'b0, 3, `MMPC_REG_PER, 0, q);
        chk("period reset", 32'h0000007D, q);
        wr(3, `MMPC_REG_PER, 32'h00000001);
        bus(1'b0, 3, `MMPC_REG_PER, 0, q);
        chk("period low", 32'h00000006, q);
        wr(3, `MMPC_REG_PER, 32'h000007D0);
        bus(1'b0, 3, `MMPC_REG_PER, 0, q);
        chk("period high", 32'h000003E8, q);
        wr(3, `MMPC_REG_CFG, 32'hFFFE0000);
        bus(1'b0, 3, `MMPC_REG_CFG, 0, q);
        chk("cfg spare", 32'h00000000, q);
        wr(2, `MMPC_REG_NONE, 32'hFFFFFFFF);
        bus(1'b0, 2, `MMPC_REG_NONE, 0, q);
        chk("unmapped", 32'h00000000, q);
        $display("regs done");
    endtask
    task automatic t_free;
        logic [31:0] v;
        logic [63:0] t1, t2;
        logic f;
        int a1, a2;
        src <= 6'h04;
        run <= 1'b1;
        wr(0, `MMPC_REG_PER, 32'h00000006);
        wr(0, `MMPC_REG_CFG, cf(MMPC_FREE, 2'h1, MMPC_OP_NONE, 0, 4, 0));
        repeat (2) nxt(0, v, t1, a1);
        nxt(0, v, t2, a2);
        chk("free count", 6, v);
        chk("free spacing", 6, a2 - a1);
        chk("ts step", 1, t2 - t1 == 86 || t2 - t1 == 87);
        run_free(0, cf(MMPC_FREE, 2'h3, MMPC_OP_NONE, 0, 4, 0), 12);
        run_free(0, cf(MMPC_FREE, 2'h2, MMPC_OP_NONE, 0, 4, 0), 6);
        fast <= 1'b1;
        run_free(0, cf(MMPC_FREE, 2'h1, MMPC_OP_NONE, 0, 4, 0), 12);
        fast <= 1'b0;
        wr(0, `MMPC_REG_CFG, 0);
        repeat (3) @(posedge clk);
        getres(0, 30, f, v, t1, a1);
        chk("disabled quiet", 0, f);
        $display("free done");
    endtask
    task automatic t_sel;
        for (int u = 0; u < 4; u++) wr(u, `MMPC_REG_PER, 32'h00000006);
        for (int s = 0; s < 36; s++) begin
            src <= 6'(s);
            run_free(s % 4, cf(MMPC_FREE, 2'h1, MMPC_OP_NONE, 0, 6'(s), 0),
                     6);
        end
        for (int u = 0; u < 4; u++) wr(u, `MMPC_REG_CFG, 0);
        $display("select done");
    endtask
    task automatic t_arith;
        logic [31:0] v1, v2;
        logic [63:0] t;
        int a;
        src <= 6'h04;
        wr(1, `MMPC_REG_CFG, cf(MMPC_FREE, 2'h1, MMPC_OP_NONE, 0, 4, 0));
        run_free(0, cf(MMPC_FREE, 2'h1, MMPC_OP_ADD, 0, 4, 0), 12);
        run_free(0, cf(MMPC_FREE, 2'h1, MMPC_OP_SUB, 0, 4, 0), 0);
        run_free(0, cf(MMPC_FREE, 2'h1, MMPC_OP_NONE, 0, 4, 0), 6);
        run_free(0, cf(MMPC_FREE, 2'h1, MMPC_OP_RSV, 0, 4, 0), 6);
        wr(0, `MMPC_REG_CFG, cf(MMPC_FREE, 2'h1, MMPC_OP_NONE, 1, 4, 0));
        repeat (2) nxt(0, v1, t, a);
        nxt(0, v2, t, a);
        chk("integ step", 6, v2 - v1);
        wr(1, `MMPC_REG_CFG, 0);
        wr(0, `MMPC_REG_CFG, 0);
        $display("arith done");
    endtask
    task automatic t_gated;
        logic [31:0] v;
        logic [63:0] t;
        logic f;
        int a, g0;
        for (int g = 0; g < 8; g++) begin
            gsrc <= 3'(g);
            wr(0, `MMPC_REG_CFG,
               cf(MMPC_GATED, 2'h1, MMPC_OP_NONE, 0, 4, 3'(g)));
            repeat (3) @(posedge clk);
            gate <= 1'b1;
            repeat (5) @(posedge clk);
            gate <= 1'b0;
            nxt(0, v, t, a);
            chk("gated count", 5, v);
        end
        gsrc <= 3'h4;
        wr(0, `MMPC_REG_PER, 32'h00000008);
        wr(0, `MMPC_REG_CFG, cf(MMPC_GFREE, 2'h1, MMPC_OP_NONE, 0, 4, 4));
        gate <= 1'b1;
        repeat (6) @(posedge clk);
        gate <= 1'b0;
        getres(0, 30, f, v, t, a);
        chk("short gate quiet", 0, f);
        gate <= 1'b1;
        g0 = cyc;
        nxt(0, v, t, a);
        gate <= 1'b0;
        chk("gated period count", 8, v);
        chk("gated period wait", 1, a - g0 >= 8);
        $display("gated done");
    endtask
    task automatic t_tag;
        logic [31:0] v;
        logic [63:0] t1, t2;
        int a1, a2;
        run <= 1'b0;
        wr(0, `MMPC_REG_PER, 32'h00000014);
        wr(0, `MMPC_REG_CFG, cf(MMPC_TAG, 2'h1, MMPC_OP_NONE, 0, 4, 0));
        repeat (3) @(posedge clk);
        pulse;
        nxt(0, v, t1, a1);
        chk("tag single", 1, v);
        pulse;
        repeat (2) @(posedge clk);
        pulse;
        nxt(0, v, t2, a2);
        chk("tag sum", 2, v);
        chk("tag holdoff", 1, a2 - a1 >= 20 && a2 - a1 <= 22);
        chk("tag time order", 1, t2 > t1);
        $display("tag done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_free;
        t_sel;
        t_arith;
        t_gated;
        t_tag;
        print_verdict;
    end
    // all tests need about a thousand cycles; this bound cuts a hang
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        print_verdict;
    end
endmodule
